// ==== common/armsg_pkg.sv ====
/*
 * Constants for the access-right and I/O explicit-message service.
 * Assumes both ends share one clock and exchange 16-bit words in order.
 */
// Function
// - Get access right: service 4E, class 306, instance 10
// - Get-right data: program number then monitor time
// - Get-right answer code CE, data size two
// - Write I/O 4D: program, offset, size, data
// - Write I/O answer CD, echo sequence, size two
// - Refresh timer 4F, program only, length eight
// - Refresh answer CF, data size two
// - Release right 50, program number only
// - Release answer D0, data size two
// - Read I/O 4B: offset and size, no program
// - Read answer CB, size four, data follows
// - Request words: length, seq, timeout, len, node/service
// - Timeout word 03E8 in every request
// - Answer echoes the request sequence number
package armsg_pkg;
    localparam logic [7:0]  SVC_GET     = 8'h4e;
    localparam logic [7:0]  SVC_WRITE   = 8'h4d;
    localparam logic [7:0]  SVC_REFRESH = 8'h4f;
    localparam logic [7:0]  SVC_RELEASE = 8'h50;
    localparam logic [7:0]  SVC_READ    = 8'h4b;
    localparam logic [7:0]  SVC_ERROR   = 8'h94;
    localparam logic [7:0]  RESP_BIT    = 8'h80;
    localparam logic [15:0] CLASS_ID    = 16'h0306;
    localparam logic [15:0] INST_ID     = 16'h0010;
    localparam logic [7:0]  NODE_ADDR   = 8'h0a;
    localparam logic [15:0] PROG_NUM    = 16'h5555;
    localparam logic [15:0] MON_TIME    = 16'h003c;
    localparam logic [15:0] TMO_WORD    = 16'h03e8;
    localparam logic [15:0] DSIZE_STD   = 16'h0002;
    localparam logic [15:0] DSIZE_READ  = 16'h0004;
    localparam logic [15:0] RX_HDR_LEN  = 16'h0006;
    localparam logic [15:0] RX_LEN_READ = 16'h0008;
    localparam logic [15:0] TOT_LEN_HDR = 16'h0006;
    localparam logic [15:0] REQ_LEN_HDR = 16'h0006;
    localparam int          MAX_WORDS   = 16;
endpackage : armsg_pkg

// ==== common/armsg_if.sv ====
/*
 * Word link between the requesting master and the service device.
 * Assumes one clock; each word is taken when valid and ready are high.
 */
`timescale 1ns/1ps
interface armsg_if;
    logic        req_valid;
    logic        req_ready;
    logic [15:0] req_word;
    logic        req_last;
    logic        rsp_valid;
    logic        rsp_ready;
    logic [15:0] rsp_word;
    logic        rsp_last;
    modport dev (input req_valid, req_word, req_last, rsp_ready,
                 output req_ready, rsp_valid, rsp_word, rsp_last);
    modport mst (output req_valid, req_word, req_last, rsp_ready,
                 input req_ready, rsp_valid, rsp_word, rsp_last);
endinterface : armsg_if

// ==== rtl/armsg_dev.sv ====
/*
 * Device end: collects a request, checks it, answers with a response.
 * Assumes the master keeps its word layout; I/O is a small word array.
 */
`timescale 1ns/1ps
module armsg_dev
    import armsg_pkg::*;
#(
    parameter int IO_WORDS = 16
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Link
    armsg_if.dev             lnk,
    // User side
    output logic             right_held_q,
    output logic [15:0]      io_out_q,
    output logic             err_seen_q
);
    typedef enum logic [1:0] {
        ST_RX   = 2'b00,
        ST_EVAL = 2'b01,
        ST_TX   = 2'b10
    } armsg_state_type;

    armsg_state_type         state_q;
    armsg_state_type         state_d;
    logic [15:0]             rxbuf_q [MAX_WORDS];
    logic [3:0]              rx_cnt_q;
    logic [2:0]              tx_cnt_q;
    logic [15:0]             io_mem_q [IO_WORDS];
    logic [7:0]              rsp_svc_q;
    logic [15:0]             rsp_dsize_q;
    logic [15:0]             rd_data_q;
    logic                    rsp_valid_q;

    // Field decode from the collected words
    wire [15:0] seq_w   = rxbuf_q[1];
    wire [7:0]  svc_w   = rxbuf_q[4][15:8];
    wire        addr_ok = rxbuf_q[4][7:0] == NODE_ADDR
                          && rxbuf_q[5] == CLASS_ID
                          && rxbuf_q[6] == INST_ID;
    wire        prog_ok = rxbuf_q[7] == PROG_NUM;
    wire [3:0]  wr_idx  = rxbuf_q[8][4:1];
    wire [3:0]  rd_idx  = rxbuf_q[7][4:1];
    wire        take    = lnk.req_valid && state_q == ST_RX;
    wire        send    = rsp_valid_q && lnk.rsp_ready;
    wire        is_get  = svc_w == SVC_GET;
    wire        is_wr   = svc_w == SVC_WRITE;
    wire        is_ref  = svc_w == SVC_REFRESH;
    wire        is_rel  = svc_w == SVC_RELEASE;
    wire        is_rd   = svc_w == SVC_READ;
    // Only get needs no held right; the rest do, read has no program
    wire        ok_w    = addr_ok && ((is_get && prog_ok)
                          || ((is_wr || is_ref || is_rel) && prog_ok
                              && right_held_q)
                          || (is_rd && right_held_q));

    // Control terms shared by the short processes below
    wire        rx_done   = take && lnk.req_last;
    wire        tx_done   = send && lnk.rsp_last;
    wire        in_eval   = state_q == ST_EVAL;
    wire        wr_en     = in_eval && ok_w && is_wr;
    wire        right_set = in_eval && ok_w && is_get;
    wire        right_clr = in_eval && ok_w && is_rel;
    wire        rsp_is_rd = rsp_svc_q == (SVC_READ | RESP_BIT);
    wire [2:0]  tx_last_w = rsp_is_rd ? 3'd4 : 3'd3;
    // Answer code and size; a refused request always reports size two
    wire [7:0]  rsp_svc_d   = ok_w ? (svc_w | RESP_BIT)
                                   : SVC_ERROR;
    wire [15:0] rsp_dsize_d = (ok_w && is_rd) ? DSIZE_READ
                                              : DSIZE_STD;

    assign lnk.req_ready = state_q == ST_RX;
    assign lnk.rsp_valid = rsp_valid_q;
    assign lnk.rsp_last  = tx_cnt_q == tx_last_w;

    // Response words: size, sequence, data size, node/service, read data
    always_comb begin
        unique case (tx_cnt_q)
            3'd0:    lnk.rsp_word = rsp_is_rd ? RX_LEN_READ : RX_HDR_LEN;
            3'd1:    lnk.rsp_word = seq_w;
            3'd2:    lnk.rsp_word = rsp_dsize_q;
            3'd3:    lnk.rsp_word = {rsp_svc_q, NODE_ADDR};
            default: lnk.rsp_word = rd_data_q;
        endcase
    end

    // Collect, spend one cycle judging, then stream the answer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RX:   if (rx_done) state_d = ST_EVAL;
            ST_EVAL: state_d = ST_TX;
            default: if (tx_done) state_d = ST_RX;
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RX;
        end else begin
            state_q <= state_d;
        end
    end

    // Word counters; words past the buffer wrap over its start
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt_q <= 4'h0;
            tx_cnt_q <= 3'h0;
        end else begin
            if (take)
                rx_cnt_q <= rx_cnt_q + 4'h1;
            else if (in_eval)
                rx_cnt_q <= 4'h0;
            if (in_eval)
                tx_cnt_q <= 3'h0;
            else if (send)
                tx_cnt_q <= tx_cnt_q + 3'h1;
        end
    end

    // Answer fields are frozen at the judging cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_q <= 1'b0;
            rsp_svc_q   <= 8'h00;
            rsp_dsize_q <= 16'h0000;
            rd_data_q   <= 16'h0000;
        end else if (in_eval) begin
            rsp_valid_q <= 1'b1;
            rsp_svc_q   <= rsp_svc_d;
            rsp_dsize_q <= rsp_dsize_d;
            rd_data_q   <= io_mem_q[rd_idx];
        end else if (tx_done) begin
            rsp_valid_q <= 1'b0;
        end
    end

    // Held right and user-side status
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            right_held_q <= 1'b0;
            io_out_q     <= 16'h0000;
            err_seen_q   <= 1'b0;
        end else begin
            if (right_set)
                right_held_q <= 1'b1;
            else if (right_clr)
                right_held_q <= 1'b0;
            if (in_eval)
                err_seen_q <= !ok_w;
            if (wr_en)
                io_out_q <= rxbuf_q[10];
        end
    end

    // Buffers have no reset so they map to plain storage; an I/O word
    // read before any write returns an unknown value
    always_ff @(posedge sys_clk) begin
        if (take)
            rxbuf_q[rx_cnt_q] <= lnk.req_word;
        if (wr_en)
            io_mem_q[wr_idx] <= rxbuf_q[10];
    end
endmodule : armsg_dev

// ==== rtl/armsg_mst.sv ====
/*
 * Master end: builds one request from user fields, collects the answer.
 * Assumes the device answers every request with a header-framed response.
 */
`timescale 1ns/1ps
module armsg_mst
    import armsg_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Link
    armsg_if.mst             lnk,
    // User request
    input  wire logic        start,
    input  wire logic [7:0]  svc,
    input  wire logic [15:0] arg_a,
    input  wire logic [15:0] arg_b,
    // User answer
    output logic             busy_q,
    output logic             done_q,
    output logic [7:0]       rsp_svc_q,
    output logic [15:0]      rsp_seq_q,
    output logic [15:0]      rsp_data_q
);
    logic [3:0]  idx_q;
    logic [3:0]  last_q;
    logic [15:0] seq_q;
    logic [7:0]  svc_q;
    logic [15:0] a_q;
    logic [15:0] b_q;
    logic        tx_q;
    logic        rx_q;
    logic [2:0]  rcnt_q;

    // Data words per service: write 4, get 2, read 2, others 1
    wire [3:0] nd_w = svc_q == SVC_WRITE ? 4'd4
                    : (svc_q == SVC_GET || svc_q == SVC_READ) ? 4'd2
                    : 4'd1;
    wire [15:0] rlen_w = REQ_LEN_HDR + {11'h0, nd_w, 1'b0};
    logic [15:0] word_w;

    // Request word order
    always_comb begin
        unique case (idx_q)
            4'd0:    word_w = rlen_w + TOT_LEN_HDR;
            4'd1:    word_w = seq_q;
            4'd2:    word_w = TMO_WORD;
            4'd3:    word_w = rlen_w;
            4'd4:    word_w = {svc_q, NODE_ADDR};
            4'd5:    word_w = CLASS_ID;
            4'd6:    word_w = INST_ID;
            4'd7:    word_w = svc_q == SVC_READ ? a_q : PROG_NUM;
            4'd8:    word_w = svc_q == SVC_READ ? b_q
                            : svc_q == SVC_GET  ? b_q : a_q;
            4'd9:    word_w = DSIZE_STD;
            default: word_w = b_q;
        endcase
    end

    assign lnk.req_valid = tx_q;
    assign lnk.req_word  = word_w;
    assign lnk.req_last  = idx_q == last_q;
    assign lnk.rsp_ready = rx_q;

    // Send the request, then gather the response
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_q      <= 4'h0;
            last_q     <= 4'h0;
            seq_q      <= 16'h0000;
            svc_q      <= 8'h00;
            a_q        <= 16'h0000;
            b_q        <= 16'h0000;
            tx_q       <= 1'b0;
            rx_q       <= 1'b0;
            rcnt_q     <= 3'h0;
            busy_q     <= 1'b0;
            done_q     <= 1'b0;
            rsp_svc_q  <= 8'h00;
            rsp_seq_q  <= 16'h0000;
            rsp_data_q <= 16'h0000;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                svc_q  <= svc;
                a_q    <= arg_a;
                b_q    <= arg_b;
                idx_q  <= 4'h0;
                tx_q   <= 1'b1;
                busy_q <= 1'b1;
                last_q <= 4'd6 + (svc == SVC_WRITE ? 4'd4
                        : (svc == SVC_GET || svc == SVC_READ) ? 4'd2
                        : 4'd1);
            end else if (tx_q && lnk.req_ready) begin
                idx_q <= idx_q + 4'h1;
                if (lnk.req_last) begin
                    tx_q   <= 1'b0;
                    rx_q   <= 1'b1;
                    rcnt_q <= 3'h0;
                end
            end else if (rx_q && lnk.rsp_valid) begin
                rcnt_q <= rcnt_q + 3'h1;
                if (rcnt_q == 3'd1) rsp_seq_q <= lnk.rsp_word;
                if (rcnt_q == 3'd3) rsp_svc_q <= lnk.rsp_word[15:8];
                if (rcnt_q == 3'd4) rsp_data_q <= lnk.rsp_word;
                if (lnk.rsp_last) begin
                    rx_q   <= 1'b0;
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    seq_q <= seq_q + 16'h0001;  // Requests numbered 0 up
                end
            end
        end
    end
endmodule : armsg_mst

// ==== bench/armsg_assertions.sv ====
/* Link checker: watches the word link between master and device ends.
   Assumes one clock, async active-low reset, frames as in the package. */
`timescale 1ns/1ps
module armsg_assertions (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // Request channel
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic [15:0] req_word,
    input wire logic        req_last,
    // Response channel
    input wire logic        rsp_valid,
    input wire logic        rsp_ready,
    input wire logic [15:0] rsp_word,
    input wire logic        rsp_last
);
    logic [3:0]  rq_idx_q;
    logic [3:0]  rs_idx_q;
    logic [15:0] seq_q;
    logic [15:0] size_q;
    wire         rq_take = req_valid && req_ready;
    wire         rs_take = rsp_valid && rsp_ready;
    wire         is_read = size_q == 16'h0008;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Word position in each frame; seq kept so the echo can be judged
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rq_idx_q <= 4'h0;
            rs_idx_q <= 4'h0;
            seq_q    <= 16'h0000;
            size_q   <= 16'h0000;
        end else begin
            if (rq_take) rq_idx_q <= req_last ? 4'h0 : rq_idx_q + 4'h1;
            if (rs_take) rs_idx_q <= rsp_last ? 4'h0 : rs_idx_q + 4'h1;
            if (rq_take && rq_idx_q == 4'h1) seq_q <= req_word;
            if (rs_take && rs_idx_q == 4'h0) size_q <= rsp_word;
        end
    end
    chk_req_held: assert property (req_valid && !req_ready |=>
        req_valid && $stable(req_word)) else $error("request word moved");
    chk_rsp_held: assert property (rsp_valid && !rsp_ready |=>
        rsp_valid && $stable(rsp_word)) else $error("answer word moved");
    chk_refuse_eval: assert property (rq_take && req_last |=>
        !req_ready) else $error("words taken while evaluating");
    chk_answer_time: assert property (rq_take && req_last |->
        ##[1:3] rsp_valid) else $error("answer late");
    chk_tmo_word: assert property (rq_take && rq_idx_q == 4'h2 |->
        req_word == 16'h03e8) else $error("timeout word wrong");
    chk_node_addr: assert property (rq_take && rq_idx_q == 4'h4 |->
        req_word[7:0] == 8'h0a) else $error("node byte wrong");
    chk_class_id: assert property (rq_take && rq_idx_q == 4'h5 |->
        req_word == 16'h0306) else $error("class word wrong");
    chk_rsp_code: assert property (rs_take && rs_idx_q == 4'h3 |->
        rsp_word[15] && rsp_word[7:0] == 8'h0a) else $error("code bad");
    chk_seq_echo: assert property (rs_take && rs_idx_q == 4'h1 |->
        rsp_word == seq_q) else $error("sequence not echoed");
    chk_data_size: assert property (rs_take && rs_idx_q == 4'h2 |->
        rsp_word == (is_read ? 16'h0004 : 16'h0002)) else $error("size");
    chk_rsp_len: assert property (rs_take && rsp_last |->
        rs_idx_q == (is_read ? 4'h4 : 4'h3)) else $error("answer length");
endmodule : armsg_assertions

// ==== bench/access_right_io_msg_server_tb.sv ====
/* Bench: master end joined to device end, driven from the user side.
   Assumes a 200 MHz clock and one request outstanding at a time. */
`timescale 1ns/1ps
module access_right_io_msg_server_tb;
    import armsg_pkg::*;
    logic        sys_clk;
    logic        rst_n;
    logic        start;
    logic [7:0]  svc;
    logic [15:0] arg_a;
    logic [15:0] arg_b;
    logic        busy_q;
    logic        done_q;
    logic        right_held_q;
    logic        err_seen_q;
    logic [7:0]  rsp_svc_q;
    logic [15:0] rsp_seq_q;
    logic [15:0] rsp_data_q;
    logic [15:0] io_out_q;
    logic [15:0] exp_seq;
    int          n_mismatch;
    int          compares;
    armsg_if lnk ();
    armsg_mst u_armsg_mst (.sys_clk(sys_clk), .rst_n(rst_n), .lnk(lnk),
        .start(start), .svc(svc), .arg_a(arg_a), .arg_b(arg_b),
        .busy_q(busy_q), .done_q(done_q), .rsp_svc_q(rsp_svc_q),
        .rsp_seq_q(rsp_seq_q), .rsp_data_q(rsp_data_q));
    armsg_dev u_armsg_dev (.sys_clk(sys_clk), .rst_n(rst_n), .lnk(lnk),
        .right_held_q(right_held_q), .io_out_q(io_out_q),
        .err_seen_q(err_seen_q));
    armsg_assertions u_armsg_assertions (.sys_clk(sys_clk), .rst_n(rst_n),
        .req_valid(lnk.req_valid), .req_ready(lnk.req_ready),
        .req_word(lnk.req_word), .req_last(lnk.req_last),
        .rsp_valid(lnk.rsp_valid), .rsp_ready(lnk.rsp_ready),
        .rsp_word(lnk.rsp_word), .rsp_last(lnk.rsp_last));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    // One request; the wait is bounded so a lost answer cannot hang us
    task automatic xfer(input logic [7:0] s, input logic [15:0] a,
                        input logic [15:0] b, input logic [7:0] code);
        int n;
        @(negedge sys_clk);
        start = 1'b1;
        svc = s;
        arg_a = a;
        arg_b = b;
        @(negedge sys_clk);
        start = 1'b0;
        check({15'h0, busy_q}, 16'h0001);
        for (n = 0; n < 200 && done_q !== 1'b1; n++) @(negedge sys_clk);
        if (n >= 200) begin
            n_mismatch++;
            close_out();
        end
        check({15'h0, busy_q}, 16'h0000);
        check({8'h00, rsp_svc_q}, {8'h00, code});
        check(rsp_seq_q, exp_seq);
        exp_seq++;
    endtask : xfer
    // Nothing but get is honoured before the right is held
    task automatic t_no_right();
        xfer(SVC_READ, 16'h0000, 16'h0002, 8'h94);
        check({15'h0, err_seen_q}, 16'h0001);
        xfer(SVC_WRITE, 16'h0000, 16'haa55, 8'h94);
        check(io_out_q, 16'h0000);
    endtask : t_no_right
    task automatic t_get_write();
        xfer(SVC_GET, 16'h0000, MON_TIME, 8'hce);
        check({15'h0, right_held_q}, 16'h0001);
        xfer(SVC_WRITE, 16'h0000, 16'haa55, 8'hcd);
        check(io_out_q, 16'haa55);
        xfer(SVC_WRITE, 16'h001e, 16'h1234, 8'hcd);
        check({15'h0, err_seen_q}, 16'h0000);
    endtask : t_get_write
    // Read back both ends of the I/O array, then refresh and a bad code
    task automatic t_read_refresh();
        xfer(SVC_READ, 16'h0000, 16'h0002, 8'hcb);
        check(rsp_data_q, 16'haa55);
        xfer(SVC_READ, 16'h001e, 16'h0002, 8'hcb);
        check(rsp_data_q, 16'h1234);
        xfer(SVC_REFRESH, 16'h0000, 16'h0000, 8'hcf);
        xfer(8'h4c, 16'h0000, 16'h0000, 8'h94);
        check({15'h0, right_held_q}, 16'h0001);
    endtask : t_read_refresh
    task automatic t_release();
        xfer(SVC_RELEASE, 16'h0000, 16'h0000, 8'hd0);
        check({15'h0, right_held_q}, 16'h0000);
        xfer(SVC_REFRESH, 16'h0000, 16'h0000, 8'h94);
    endtask : t_release
    // Reset in mid-run drops the right and restarts the numbering
    task automatic t_reset();
        xfer(SVC_GET, 16'h0000, MON_TIME, 8'hce);
        @(negedge sys_clk);
        rst_n = 1'b0;
        @(negedge sys_clk);
        check({15'h0, right_held_q}, 16'h0000);
        rst_n = 1'b1;
        exp_seq = 16'h0000;
        xfer(SVC_REFRESH, 16'h0000, 16'h0000, 8'h94);
    endtask : t_reset
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        svc = 8'h00;
        arg_a = 16'h0000;
        arg_b = 16'h0000;
        exp_seq = 16'h0000;
        n_mismatch = 0;
        compares = 0;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        t_no_right();
        t_get_write();
        t_read_refresh();
        t_release();
        t_reset();
        close_out();
    end
endmodule : access_right_io_msg_server_tb
